// ==== core/option_byte_config_decode.v ====
// What this block does
// - Halt entry resets when option set, watchdog active
// - Watchdog type: hardware always on, software-enabled
// - Brown-out threshold decode, 11 means off
// - Sector zero size code 0.5/1/2/4 KB
// - Read-out protection blocks programming-mode reads and flash writes
// - Option erase under read-out protection also pulses a whole-memory erase, one cycle after the strobe
// - Write protection permanently blocks program and itself
// - Reset delay 4096 or 256 CPU cycles
// - Oscillator range decode, reserved and external codes
// - Internal RC on when bit zero
// - Halving enabled at zero; tool keeps rules
// - PLL factor times four or eight
// - PLL bypassed when bit one
// - Package select decode 32/44/48 pins
// - Secondary I2C slave enabled at zero
// - Option bytes accessible only in programming mode
// - Unprogrammed bytes read as all ones, except reserved bits, which read as zero
//
// Decodes three of the four option bytes into static configuration.
// Assumes a programming port driven by an external tool, sync inputs.
`timescale 1ns/1ps
`include "option_byte_defs.vh"

module option_byte_config_decode #(
  parameter BLANK_PART = 1
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_b_i,
  // Programming port
  input wire prog_mode_i,
  input wire [1:0] opt_sel_i,
  input wire opt_wr_i,
  input wire opt_rd_i,
  input wire opt_erase_i,
  input wire [7:0] opt_wdata_i,
  output reg [7:0] opt_rdata_o,
  output reg opt_refused_o,
  output reg mem_erase_o,
  // Runtime events
  input wire halt_entry_i,
  input wire watchdog_sw_enable_i,
  input wire mem_read_i,
  input wire mem_write_i,
  input wire cpu_tick_i,
  // Decoded configuration
  output reg halt_watchdog_reset_opt_o,
  output reg watchdog_type_select_o,
  output reg watchdog_active_o,
  output reg halt_reset_o,
  output reg brownout_enable_o,
  output reg [1:0] brownout_threshold_select_o,
  output reg [2:0] first_sector_size_o,
  output reg readout_protect_o,
  output reg program_write_protect_o,
  output reg mem_read_block_o,
  output reg mem_write_block_o,
  output reg reset_delay_select_o,
  output reg reset_phase_o,
  output reg [2:0] osc_range_select_o,
  output reg osc_external_o,
  output reg osc_range_reserved_o,
  output reg rc_osc_enable_o,
  output reg pll_halve_enable_o,
  output reg pll_factor_select_o,
  output reg pll_enable_o,
  output reg [1:0] package_select_o,
  output reg slave_i2c_block_select_o
);
  // Power-up cell contents: blank part or shipped defaults
  localparam [7:0] INIT0 = BLANK_PART ? `OPT_ERASED : `OPT0_DEFAULT;
  localparam [7:0] INIT1 = BLANK_PART ? `OPT_ERASED : `OPT1_DEFAULT;
  localparam [7:0] INIT3 = BLANK_PART ? `OPT_ERASED & `B3_RSVD_MASK : `OPT3_DEFAULT;

  // Reset sequencer states
  localparam [2:0] ST_LATCH = 3'h1;
  localparam [2:0] ST_DELAY = 3'h2;
  localparam [2:0] ST_RUN = 3'h4;

  wire [7:0] byte0;
  wire [7:0] byte1;
  wire [7:0] byte2;
  wire [7:0] byte3;
  reg [7:0] cfg0;
  reg [7:0] cfg1;
  reg [7:0] cfg3;
  reg [2:0] state;
  reg [12:0] dly_cnt;
  wire locked;
  wire acc_ok;
  wire wr_ok;
  wire erase_ok;
  wire any_req;
  wire mod_req;
  wire delay_done;

  // Access allowed only in programming mode
  assign acc_ok = prog_mode_i;
  // Write protection freezes the option bytes for good
  assign locked = byte0[`B0_WR_PROT];
  assign erase_ok = acc_ok & opt_erase_i & ~locked;
  assign wr_ok = acc_ok & opt_wr_i & ~opt_erase_i & ~locked;

  // Any strobe, and the ones that would change a cell
  assign any_req = opt_wr_i | opt_rd_i | opt_erase_i;
  assign mod_req = opt_wr_i | opt_erase_i;
  // Last counted tick ends the reset phase; decode sees it in the same edge
  assign delay_done = (state == ST_DELAY) & cpu_tick_i & (dly_cnt == 13'h0001);

  // Option byte cells
  // Cells keep their content through reset, as the flash they stand for
  option_byte_store #(.INIT(INIT0), .KEEP_MASK(8'hff)) u_byte0 (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .wr_i(wr_ok && opt_sel_i == `OPT_SEL_ZERO),
    .erase_i(erase_ok),
    .wdata_i(opt_wdata_i),
    .value_o(byte0)
  );
  option_byte_store #(.INIT(INIT1), .KEEP_MASK(8'hff)) u_byte1 (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .wr_i(wr_ok && opt_sel_i == `OPT_SEL_ONE),
    .erase_i(erase_ok),
    .wdata_i(opt_wdata_i),
    .value_o(byte1)
  );
  // Reserved byte held cleared
  option_byte_store #(.INIT(`OPT2_DEFAULT), .KEEP_MASK(8'h00)) u_byte2 (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .wr_i(wr_ok && opt_sel_i == `OPT_SEL_TWO),
    .erase_i(erase_ok),
    .wdata_i(opt_wdata_i),
    .value_o(byte2)
  );
  // Reserved low bits held cleared
  option_byte_store #(.INIT(INIT3), .KEEP_MASK(`B3_RSVD_MASK)) u_byte3 (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .wr_i(wr_ok && opt_sel_i == `OPT_SEL_THREE),
    .erase_i(erase_ok),
    .wdata_i(opt_wdata_i),
    .value_o(byte3)
  );

  // Refusal and whole-memory erase pulses, one cycle each
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      opt_refused_o <= 1'b0;
      mem_erase_o <= 1'b0;
    end else begin
      opt_refused_o <= any_req & (~acc_ok | (mod_req & locked));
      // Protected content must go before the options can be rewritten
      mem_erase_o <= erase_ok & byte0[`B0_RD_PROT];
    end
  end

  // Read data stands one cycle, zero otherwise
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      opt_rdata_o <= 8'h00;
    end else if (opt_rd_i && acc_ok) begin
      case (opt_sel_i)
        `OPT_SEL_ZERO: opt_rdata_o <= byte0;
        `OPT_SEL_ONE: opt_rdata_o <= byte1;
        `OPT_SEL_TWO: opt_rdata_o <= byte2;
        default: opt_rdata_o <= byte3;
      endcase
    end else begin
      opt_rdata_o <= 8'h00;
    end
  end

  // Reset sequencer: latch options, then count the reset delay
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_LATCH;
      cfg0 <= 8'h00;
      cfg1 <= 8'h00;
      cfg3 <= 8'h00;
      dly_cnt <= 13'h0000;
      reset_phase_o <= 1'b1;
    end else begin
      case (state)
        ST_LATCH: begin
          // Bytes are taken once; later writes wait for the next reset
          cfg0 <= byte0;
          cfg1 <= byte1;
          cfg3 <= byte3;
          dly_cnt <= byte1[`B1_RST_DLY] ? `RST_DLY_SHORT : `RST_DLY_LONG;
          state <= ST_DELAY;
        end
        ST_DELAY: begin
          // Count CPU cycles, not system clocks
          if (cpu_tick_i) begin
            if (dly_cnt == 13'h0001) begin
              state <= ST_RUN;
              reset_phase_o <= 1'b0;
            end
            dly_cnt <= dly_cnt - 13'h0001;
          end
        end
        ST_RUN: begin
          // Configuration now stands until the next reset
          state <= ST_RUN;
        end
        default: begin
          state <= ST_LATCH;
        end
      endcase
    end
  end

  // Watchdog and halt reset
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      halt_watchdog_reset_opt_o <= 1'b0;
      watchdog_type_select_o <= 1'b0;
      watchdog_active_o <= 1'b0;
      halt_reset_o <= 1'b0;
    end else begin
      halt_watchdog_reset_opt_o <= cfg0[`B0_HALT_RST];
      watchdog_type_select_o <= cfg0[`B0_WDG_TYPE];
      // Hardware watchdog runs from the edge that ends the reset phase, with no gap
      if (!cfg0[`B0_WDG_TYPE] && (state == ST_RUN || delay_done)) begin
        watchdog_active_o <= 1'b1;
      end else if (watchdog_sw_enable_i && state == ST_RUN) begin
        watchdog_active_o <= 1'b1;
      end
      // Halt reset only while the watchdog is already running
      halt_reset_o <= halt_entry_i & cfg0[`B0_HALT_RST] & watchdog_active_o;
    end
  end

  // Supply monitor and first sector size
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      brownout_enable_o <= 1'b0;
      brownout_threshold_select_o <= 2'h0;
      first_sector_size_o <= 3'h0;
    end else begin
      // Code 11 switches the monitor off
      brownout_enable_o <= ~(cfg0[`B0_BOR_HI] & cfg0[`B0_BOR_LO]);
      brownout_threshold_select_o <= cfg0[`B0_BOR_HI:`B0_BOR_LO];
      // Size in half-kilobyte shifts: 0=0.5K .. 3=4K
      first_sector_size_o <= {1'b0, cfg0[`B0_SEC_HI:`B0_SEC_LO]};
    end
  end

  // Memory protection
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      readout_protect_o <= 1'b0;
      program_write_protect_o <= 1'b0;
      mem_read_block_o <= 1'b0;
      mem_write_block_o <= 1'b0;
    end else begin
      readout_protect_o <= cfg0[`B0_RD_PROT];
      program_write_protect_o <= cfg0[`B0_WR_PROT];
      // Read blocking covers the external extraction path only
      mem_read_block_o <= mem_read_i & cfg0[`B0_RD_PROT] & prog_mode_i;
      mem_write_block_o <= mem_write_i & (cfg0[`B0_RD_PROT] | cfg0[`B0_WR_PROT]);
    end
  end

  // Clock source and PLL
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reset_delay_select_o <= 1'b0;
      osc_range_select_o <= 3'h0;
      osc_external_o <= 1'b0;
      osc_range_reserved_o <= 1'b0;
      rc_osc_enable_o <= 1'b0;
      pll_halve_enable_o <= 1'b0;
      pll_factor_select_o <= 1'b0;
      pll_enable_o <= 1'b0;
    end else begin
      reset_delay_select_o <= cfg1[`B1_RST_DLY];
      osc_range_select_o <= cfg1[`B1_OSC_HI:`B1_OSC_LO];
      // Reserved range codes are flagged, never acted on
      osc_external_o <= cfg1[`B1_RC_SEL] & cfg1[`B1_OSC_HI] & cfg1[`B1_OSC_LO + 1];
      osc_range_reserved_o <= cfg1[`B1_RC_SEL] & cfg1[`B1_OSC_HI] & ~cfg1[`B1_OSC_LO + 1];
      rc_osc_enable_o <= ~cfg1[`B1_RC_SEL];
      pll_halve_enable_o <= ~cfg1[`B1_HALVE];
      pll_factor_select_o <= cfg1[`B1_FACTOR];
      pll_enable_o <= ~cfg1[`B1_BYPASS];
    end
  end

  // Package and secondary slave
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      package_select_o <= 2'h0;
      slave_i2c_block_select_o <= 1'b0;
    end else begin
      package_select_o <= cfg3[`B3_PKG_HI:`B3_PKG_LO];
      slave_i2c_block_select_o <= ~cfg3[`B3_I2C_SEL];
    end
  end
endmodule

// ==== core/option_byte_defs.vh ====
// Option byte field positions, reset values and timing counts.
// Included by the option byte decode modules; definitions only.
`ifndef OPTION_BYTE_DEFS_VH
`define OPTION_BYTE_DEFS_VH

// Erased content of an unprogrammed byte
`define OPT_ERASED 8'hff
// Shipped default contents
`define OPT0_DEFAULT 8'hfc
`define OPT1_DEFAULT 8'hf7
`define OPT2_DEFAULT 8'h00
`define OPT3_DEFAULT 8'hc0

// Byte selects on the programming port
`define OPT_SEL_ZERO 2'h0
`define OPT_SEL_ONE 2'h1
`define OPT_SEL_TWO 2'h2
`define OPT_SEL_THREE 2'h3

// Byte zero fields
`define B0_HALT_RST 7
`define B0_WDG_TYPE 6
`define B0_BOR_HI 5
`define B0_BOR_LO 4
`define B0_SEC_HI 3
`define B0_SEC_LO 2
`define B0_RD_PROT 1
`define B0_WR_PROT 0
// Byte one fields
`define B1_RST_DLY 7
`define B1_OSC_HI 6
`define B1_OSC_LO 4
`define B1_RC_SEL 3
`define B1_HALVE 2
`define B1_FACTOR 1
`define B1_BYPASS 0
// Byte three fields
`define B3_PKG_HI 7
`define B3_PKG_LO 6
`define B3_I2C_SEL 5
`define B3_RSVD_MASK 8'he0

// Reset delay counts in CPU cycles
`define RST_DLY_LONG 13'h1000
`define RST_DLY_SHORT 13'h0100

`endif

// ==== core/option_byte_store.v ====
// One non-volatile option byte cell with erase and write.
// Assumes the caller gates access by programming mode and protection.
`timescale 1ns/1ps
`include "option_byte_defs.vh"

module option_byte_store #(
  parameter [7:0] INIT = 8'hff,
  parameter [7:0] KEEP_MASK = 8'hff
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_b_i,
  // Access
  input wire wr_i,
  input wire erase_i,
  input wire [7:0] wdata_i,
  // Stored value
  output reg [7:0] value_o
);
  // Power-up content; the cell is non-volatile, so reset leaves it alone
  initial begin
    value_o = INIT;
  end

  // Erase or write outside reset; bits outside the mask hold zero
  always @(posedge clk_sys_i) begin
    if (rst_b_i && erase_i) begin
      value_o <= `OPT_ERASED & KEEP_MASK;
    end else if (rst_b_i && wr_i) begin
      value_o <= wdata_i & KEEP_MASK;
    end
  end
endmodule

// ==== tb/opt_props.sv ====
// Checker for the option byte decode block, bound from the bench
// Sees only top ports; watchdog type, brown-out, sector and package outputs are judged once the reset delay ends
`timescale 1ns/1ps
module opt_props (
  // Clock, reset, option port and halt entry
  input wire clk_sys_i, rst_b_i, prog_mode_i, opt_wr_i, opt_rd_i, opt_erase_i,
  input wire [7:0] opt_rdata_o,
  input wire opt_refused_o, mem_erase_o, halt_entry_i,
  // Decoded configuration
  input wire halt_watchdog_reset_opt_o, watchdog_type_select_o, watchdog_active_o, halt_reset_o,
  input wire brownout_enable_o, program_write_protect_o, reset_phase_o,
  input wire [1:0] brownout_threshold_select_o, package_select_o,
  input wire [2:0] first_sector_size_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  refuse_idle_a: assert property (!prog_mode_i && opt_wr_i |=> opt_refused_o)
    else $error("write outside programming mode not refused");
  read_idle_a: assert property (!prog_mode_i && opt_rd_i |=> opt_rdata_o == 8'h00)
    else $error("read outside programming mode returned data");
  halt_reset_a: assert property (halt_entry_i && halt_watchdog_reset_opt_o && watchdog_active_o
    |-> ##[1:2] halt_reset_o) else $error("halt entry gave no reset");
  no_halt_a: assert property (!halt_watchdog_reset_opt_o |-> !halt_reset_o)
    else $error("halt reset with option clear");
  hw_wdg_a: assert property (!reset_phase_o && !watchdog_type_select_o |-> watchdog_active_o)
    else $error("hardware watchdog not active");
  bor_off_a: assert property (!reset_phase_o |-> brownout_enable_o == (brownout_threshold_select_o != 2'h3))
    else $error("brown-out enable wrong");
  cfg_hold_a: assert property (!reset_phase_o |=> $stable(first_sector_size_o) && $stable(package_select_o))
    else $error("config changed outside reset");
  erase_cause_a: assert property (mem_erase_o |-> $past(opt_erase_i) && $past(prog_mode_i))
    else $error("memory erase without option erase");
  wp_refuse_a: assert property (prog_mode_i && opt_wr_i && program_write_protect_o |=> opt_refused_o)
    else $error("write under write protection not refused");
endmodule

// ==== tb/option_byte_config_decode_bench.sv ====
// Bench for the option byte decode block
// Runtime pins driven here, option port through the tool model
`timescale 1ns/1ps
module option_byte_config_decode_bench;
  reg clk_sys_i = 1'b0;
  reg rst_b_i = 1'b0;
  reg halt_entry_i = 1'b0;
  reg sw_en = 1'b0;
  reg mem_rd = 1'b0;
  reg mem_wr = 1'b0;
  reg tick = 1'b0;
  wire pm, wr, rd, er, refused, merase, hopt, wtype, wact, hrst, boren, rp, wp, rpb, wpb;
  wire rdsel, rph, ext, rsv, rc, halve, fact, pll, i2c;
  wire [1:0] sel, thr, package_select;
  wire [2:0] sec, osc;
  wire [7:0] wd, rdat;
  wire [22:0] cfg = {hopt, wtype, boren, thr, sec, rp, wp, rdsel, osc, ext, rsv, rc, halve, fact, pll, package_select, i2c};
  integer err_total = 0;
  integer tests_run = 0;
  integer n;
  reg [7:0] q;
  reg s;
  option_byte_config_decode #(.BLANK_PART(0)) dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .prog_mode_i(pm),
    .opt_sel_i(sel), .opt_wr_i(wr), .opt_rd_i(rd), .opt_erase_i(er), .opt_wdata_i(wd), .opt_rdata_o(rdat),
    .opt_refused_o(refused), .mem_erase_o(merase), .halt_entry_i(halt_entry_i), .watchdog_sw_enable_i(sw_en),
    .mem_read_i(mem_rd), .mem_write_i(mem_wr), .cpu_tick_i(tick), .halt_watchdog_reset_opt_o(hopt),
    .watchdog_type_select_o(wtype), .watchdog_active_o(wact), .halt_reset_o(hrst), .brownout_enable_o(boren),
    .brownout_threshold_select_o(thr), .first_sector_size_o(sec), .readout_protect_o(rp),
    .program_write_protect_o(wp), .mem_read_block_o(rpb), .mem_write_block_o(wpb), .reset_delay_select_o(rdsel),
    .reset_phase_o(rph), .osc_range_select_o(osc), .osc_external_o(ext), .osc_range_reserved_o(rsv),
    .rc_osc_enable_o(rc), .pll_halve_enable_o(halve), .pll_factor_select_o(fact), .pll_enable_o(pll),
    .package_select_o(package_select), .slave_i2c_block_select_o(i2c));
  prog_tool tool (.clk_sys_i(clk_sys_i), .rdata_i(rdat), .prog_mode_o(pm), .sel_o(sel), .wr_o(wr), .rd_o(rd),
    .erase_o(er), .wdata_o(wd));
  // CPU cycle enable at half the system clock
  always @(posedge clk_sys_i) tick <= ~tick;
  // Expected config worked out from the three option bytes
  function [22:0] want(input [7:0] a, input [7:0] b, input [7:0] c);
    want = {a[7], a[6], a[5:4] != 2'h3, a[5:4], 1'b0, a[3:2], a[1], a[0], b[7], b[6:4],
      b[3] && b[6:5] == 2'h3, b[3] && b[6:5] == 2'h2, !b[3], !b[2], b[1], !b[0], c[7:6], !c[5]};
  endfunction
  task chk(input [8*8-1:0] what, input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  // Reset, then count cycles until the reset delay ends
  task do_reset;
    begin
      @(posedge clk_sys_i) rst_b_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      n = 0;
      #1;
      while (rph !== 1'b0 && n < 10000) begin
        @(posedge clk_sys_i);
        #1 n = n + 1;
      end
    end
  endtask
  task halt_try(input exp);
    begin
      @(posedge clk_sys_i) halt_entry_i <= 1'b1;
      @(posedge clk_sys_i) halt_entry_i <= 1'b0;
      s = 1'b0;
      repeat (3) begin
        #1 s = s | hrst;
        @(posedge clk_sys_i);
      end
      chk("halt", s, exp);
    end
  endtask
  task t_defaults;
    begin
      do_reset;
      chk("dly256", n >= 512 && n <= 516, 1);
      chk("cfg", cfg, want(8'hfc, 8'hf7, 8'hc0));
      tool.acc(2'h0, 2'h0, 8'h5a, 1'b0, q);
      chk("refuse", refused, 1);
      tool.acc(2'h1, 2'h0, 8'h00, 1'b1, q);
      chk("byte0", q, 8'hfc);
      tool.acc(2'h1, 2'h2, 8'h00, 1'b1, q);
      chk("byte2", q, 8'h00);
    end
  endtask
  task t_program;
    begin
      tool.acc(2'h0, 2'h0, 8'h02, 1'b1, q);
      tool.acc(2'h0, 2'h1, 8'h0c, 1'b1, q);
      tool.acc(2'h0, 2'h3, 8'h20, 1'b1, q);
      tool.acc(2'h1, 2'h3, 8'h00, 1'b1, q);
      chk("byte3", q, 8'h20);
      chk("hold", cfg, want(8'hfc, 8'hf7, 8'hc0));
      do_reset;
      chk("dly4096", n >= 8192 && n <= 8196, 1);
      chk("cfg", cfg, want(8'h02, 8'h0c, 8'h20));
      chk("hw_wdg", wact, 1);
      halt_try(1'b0);
      @(posedge clk_sys_i) mem_rd <= 1'b1;
      mem_wr <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      #1 chk("blocks", {rpb, wpb}, 2'h3);
      @(posedge clk_sys_i) mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      tool.acc(2'h0, 2'h1, 8'hcc, 1'b1, q);
      do_reset;
      chk("rsv_osc", cfg, want(8'h02, 8'hcc, 8'h20));
    end
  endtask
  task t_erase;
    begin
      tool.acc(2'h2, 2'h0, 8'h00, 1'b1, q);
      chk("merase", merase, 1);
      tool.acc(2'h1, 2'h0, 8'h00, 1'b1, q);
      chk("erased", q, 8'hff);
    end
  endtask
  task t_locked;
    begin
      do_reset;
      chk("cfg", cfg, want(8'hff, 8'hff, 8'he0));
      tool.acc(2'h0, 2'h0, 8'h00, 1'b1, q);
      chk("wp_wr", refused, 1);
      tool.acc(2'h2, 2'h1, 8'h00, 1'b1, q);
      chk("wp_er", refused, 1);
      tool.acc(2'h1, 2'h0, 8'h00, 1'b1, q);
      chk("locked", q, 8'hff);
      halt_try(1'b0);
      @(posedge clk_sys_i) sw_en <= 1'b1;
      halt_try(1'b1);
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #100000;
    err_total = err_total + 1;
    stop_test;
  end
  initial begin
    t_defaults;
    t_program;
    t_erase;
    t_locked;
    stop_test;
  end
endmodule
bind option_byte_config_decode opt_props props (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
  .prog_mode_i(prog_mode_i), .opt_wr_i(opt_wr_i), .opt_rd_i(opt_rd_i), .opt_erase_i(opt_erase_i),
  .opt_rdata_o(opt_rdata_o), .opt_refused_o(opt_refused_o), .mem_erase_o(mem_erase_o),
  .halt_entry_i(halt_entry_i), .halt_watchdog_reset_opt_o(halt_watchdog_reset_opt_o),
  .watchdog_type_select_o(watchdog_type_select_o), .watchdog_active_o(watchdog_active_o),
  .halt_reset_o(halt_reset_o), .brownout_enable_o(brownout_enable_o),
  .program_write_protect_o(program_write_protect_o), .reset_phase_o(reset_phase_o),
  .brownout_threshold_select_o(brownout_threshold_select_o), .package_select_o(package_select_o),
  .first_sector_size_o(first_sector_size_o));

// ==== tb/prog_tool.sv ====
// Programming tool model driving the option port
// Assumes the block answers one cycle after a strobe
`timescale 1ns/1ps
module prog_tool (
  // Clock and answer
  input wire clk_sys_i,
  input wire [7:0] rdata_i,
  // Port drive
  output reg prog_mode_o = 1'b0,
  output reg [1:0] sel_o = 2'h0,
  output reg wr_o = 1'b0,
  output reg rd_o = 1'b0,
  output reg erase_o = 1'b0,
  output reg [7:0] wdata_o = 8'h00
);
  // One access: k 0 write, 1 read, 2 erase; m is the mode level held after
  task acc(input [1:0] k, input [1:0] s, input [7:0] d, input m, output [7:0] q);
    begin
      @(posedge clk_sys_i);
      prog_mode_o <= m;
      sel_o <= s;
      wdata_o <= d;
      wr_o <= (k == 2'h0);
      rd_o <= (k == 2'h1);
      erase_o <= (k == 2'h2);
      @(posedge clk_sys_i);
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      erase_o <= 1'b0;
      wdata_o <= ~d;
      #1 q = rdata_i;
    end
  endtask
endmodule
